// ===== core/mip_pkg.sv
package mip_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int MIP_CLK_PERIOD_NS = 8;
	localparam int MIP_RAMP_STEP_NS = 1000;
	// Longest wait rounds up so a ramp step never runs faster than asked
	localparam int MIP_RAMP_STEP_CYCLES = (MIP_RAMP_STEP_NS + MIP_CLK_PERIOD_NS - 1) / MIP_CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_MIX1_CTRL = 8'h2C;
	localparam logic [7:0] IDX_MIX1_GAIN = 8'h2D;
	localparam logic [7:0] IDX_MIX2_CTRL = 8'h2E;
	localparam logic [7:0] IDX_MIX2_GAIN = 8'h2F;
	localparam logic [7:0] IDX_MIX_STATUS = 8'h30;
	localparam logic [7:0] IDX_PRE1_GAIN = 8'hB5;
	localparam logic [7:0] IDX_PRE1_SRC = 8'hB7;
	localparam logic [7:0] IDX_PRE2_CTRL = 8'hB8;
	localparam logic [7:0] IDX_PRE2_GAIN = 8'hB9;
	localparam logic [7:0] IDX_PRE2_SRC = 8'hBB;
	localparam logic [7:0] IDX_BIAS_SETUP = 8'hFC;
	localparam logic [7:0] IDX_BIAS_EN = 8'hFD;

	// ----------------------------------------------------------------
	// Storage slots, masks of defined bits and reset values
	// ----------------------------------------------------------------
	localparam int NUM_REGS = 11;
	localparam logic [3:0] SLOT_MIX1_CTRL = 4'h0;
	localparam logic [3:0] SLOT_MIX1_GAIN = 4'h1;
	localparam logic [3:0] SLOT_MIX2_CTRL = 4'h2;
	localparam logic [3:0] SLOT_MIX2_GAIN = 4'h3;
	localparam logic [3:0] SLOT_PRE1_GAIN = 4'h4;
	localparam logic [3:0] SLOT_PRE1_SRC = 4'h5;
	localparam logic [3:0] SLOT_PRE2_CTRL = 4'h6;
	localparam logic [3:0] SLOT_PRE2_GAIN = 4'h7;
	localparam logic [3:0] SLOT_PRE2_SRC = 4'h8;
	localparam logic [3:0] SLOT_BIAS_SETUP = 4'h9;
	localparam logic [3:0] SLOT_BIAS_EN = 4'hA;
	localparam logic [3:0] SLOT_NONE = 4'hF;

	localparam logic [7:0] REG_IDX [NUM_REGS] = '{IDX_MIX1_CTRL, IDX_MIX1_GAIN, IDX_MIX2_CTRL, IDX_MIX2_GAIN,
		IDX_PRE1_GAIN, IDX_PRE1_SRC, IDX_PRE2_CTRL, IDX_PRE2_GAIN, IDX_PRE2_SRC, IDX_BIAS_SETUP, IDX_BIAS_EN};
	localparam logic [7:0] REG_MASK [NUM_REGS] = '{8'hF8, 8'h0F, 8'hF8, 8'h0F,
		8'h07, 8'h03, 8'hC0, 8'h07, 8'h03, 8'hFF, 8'h11};
	localparam logic [7:0] REG_RESET [NUM_REGS] = '{8'h48, 8'h03, 8'h48, 8'h03,
		8'h01, 8'h00, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00};

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int AMP_EN_BIT = 7;
	localparam int AMP_MUTE_BIT = 6;
	localparam int MIX_RAMP_BIT = 5;
	localparam int MIX_ZC_BIT = 4;
	localparam int MIX_SEL_BIT = 3;
	localparam int MIX_GAIN_LSB = 0;
	localparam int MIX_GAIN_W = 4;
	localparam int PRE_GAIN_LSB = 0;
	localparam int PRE_GAIN_W = 3;
	localparam int PRE_SRC_LSB = 0;
	localparam int PRE_SRC_W = 2;
	localparam int BIAS2_LP_BIT = 7;
	localparam int BIAS2_LEVEL_LSB = 4;
	localparam int BIAS1_LP_BIT = 3;
	localparam int BIAS1_LEVEL_LSB = 0;
	localparam int BIAS_LEVEL_W = 3;
	localparam int BIAS2_EN_BIT = 4;
	localparam int BIAS1_EN_BIT = 0;
	localparam int STAT_GAIN2_LSB = 4;
	localparam int STAT_BUSY1_BIT = 8;
	localparam int STAT_BUSY2_BIT = 9;
	localparam logic [3:0] MIX_GAIN_RESET = 4'h3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SRC_DIFF, SRC_POS_ONLY, SRC_NEG_ONLY, SRC_RESERVED} mip_source_e;

	typedef struct packed {
		mip_source_e source;
		logic [2:0] gain;
	} mip_preamp_s;

	typedef struct packed {
		logic enable;
		logic low_power;
		logic [2:0] level;
	} mip_bias_s;

	typedef struct packed {
		logic enable;
		logic mute;
		logic mix_sel;
		logic [3:0] gain;
	} mip_mixer_s;

endpackage

// ===== core/mip_gain_apply.sv
`timescale 1ns/10ps
module mip_gain_apply
	import mip_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [3:0] target,
	input wire logic ramp_en,
	input wire logic zc_en,
	input wire logic ramp_tick,
	input wire logic zero_cross,
	output logic [3:0] applied,
	output logic busy
);

	assign busy = (applied != target);

	// ----------------------------------------------------------------
	// Applied gain follows the programmed gain
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			applied <= MIX_GAIN_RESET;
		end else if (ce && busy) begin
			if (ramp_en) begin
				// Ramping wins even when zero-cross is also set
				if (ramp_tick) begin
					if (applied < target) begin
						applied <= applied + 4'h1;
					end else begin
						applied <= applied - 4'h1;
					end
				end
			end else if (zc_en) begin
				if (zero_cross) begin
					applied <= target;
				end
			end else begin
				applied <= target;
			end
		end
	end

endmodule

// ===== core/mip_regs.sv
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
// What this block does
// - Preamp one gain, 3 bits, -6 dB to 36 dB in 6 dB steps, resets 001.
// - Preamp two gain, same 3-bit coding, resets 001.
// - Preamp one source: 00 differential, 01 positive, 10 negative, 11 reserved; resets 00.
// - Preamp two source uses the same coding and resets 00.
// - Preamp two control bit 7 enables the amplifier; resets off.
// - Preamp two control bit 6 mutes the amplifier; resets muted.
// - Bias two level in bits 6:4, 1.6 V to 3.0 V in 0.2 V steps.
// - Bias one level in bits 2:0, same coding, resets 000.
// - Low-power bits: bit 7 bias two, bit 3 bias one; reset normal.
// - Enable register bit 4 turns on bias two, bit 0 bias one.
// - Mixer control: enable 7, mute 6, ramp 5, zero-cross 4, select 3.
// - Ramp set moves gain gradually and overrides zero-cross; ramp and zero-cross both clear means immediate.
// - Zero-cross set delays a new gain until the signal crosses zero.
// - Mixer gain 4 bits, -4.5 dB to 18 dB in 1.5 dB steps, resets 3.
module mip_regs
	import mip_pkg::*;
#(
	parameter int RAMP_STEP_CYCLES = MIP_RAMP_STEP_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic zero_cross_one,
	input wire logic zero_cross_two,
	output mip_preamp_s preamp_one,
	output mip_preamp_s preamp_two,
	output logic preamp_two_enable,
	output logic preamp_two_mute,
	output mip_bias_s bias_one,
	output mip_bias_s bias_two,
	output mip_mixer_s mixer_one,
	output mip_mixer_s mixer_two
);

	// The step timer is 16 bits wide
	if (RAMP_STEP_CYCLES < 1 || RAMP_STEP_CYCLES > 65536) begin : gen_bad_ramp
		$error("RAMP_STEP_CYCLES must lie between 1 and 65536");
	end

	typedef enum logic {BUS_IDLE, BUS_ANSWER} mip_bus_e;

	mip_bus_e bus_state;
	logic [7:0] regs [NUM_REGS];
	logic wr_fire;
	logic [3:0] wr_slot;
	logic [3:0] rd_slot;
	logic [31:0] next_readdata;
	logic [3:0] applied_one;
	logic [3:0] applied_two;
	logic busy_one;
	logic busy_two;
	logic [15:0] ramp_count;
	logic ramp_tick;
	logic [1:0] zc_meta;
	logic [1:0] zc_sync;
	logic [1:0] zc_last;
	logic [1:0] zc_event;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic [3:0] slot_of(input logic [7:0] idx);
		logic [3:0] slot;
		slot = SLOT_NONE;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (REG_IDX[i] == idx) begin
				slot = 4'(i);
			end
		end
		return slot;
	endfunction

	assign wr_slot = slot_of(avs_address);
	assign rd_slot = slot_of(avs_address);

	// ----------------------------------------------------------------
	// Avalon-MM slave: one cycle of wait, then one cycle of answer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bus_state <= BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else if (ce) begin
			case (bus_state)
				BUS_IDLE: begin
					if (avs_read || avs_write) begin
						avs_waitrequest <= 1'b0;
						if (avs_read) begin
							avs_readdata <= next_readdata;
						end
						bus_state <= BUS_ANSWER;
					end
				end
				BUS_ANSWER: begin
					avs_waitrequest <= 1'b1;
					bus_state <= BUS_IDLE;
				end
				default: begin
					avs_waitrequest <= 1'b1;
					bus_state <= BUS_IDLE;
				end
			endcase
		end
	end

	// Write lands on the edge where the master sees waitrequest low
	assign wr_fire = ce && (bus_state == BUS_ANSWER) && avs_write && avs_byteenable[0];

	// Read data: unmapped indices answer zero rather than an error
	always_comb begin
		next_readdata = 32'h0000_0000;
		if (rd_slot != SLOT_NONE) begin
			next_readdata[7:0] = regs[rd_slot[3:0]];
		end else if (avs_address == IDX_MIX_STATUS) begin
			next_readdata[MIX_GAIN_W-1:0] = applied_one;
			next_readdata[STAT_GAIN2_LSB +: MIX_GAIN_W] = applied_two;
			next_readdata[STAT_BUSY1_BIT] = busy_one;
			next_readdata[STAT_BUSY2_BIT] = busy_two;
		end
	end

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	// Masking on write keeps reserved bits at zero without a read-side mask
	generate
		for (genvar g = 0; g < NUM_REGS; g++) begin : gen_reg
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					regs[g] <= REG_RESET[g];
				end else if (wr_fire && wr_slot == 4'(g)) begin
					regs[g] <= avs_writedata[7:0] & REG_MASK[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Preamplifier and bias controls
	// ----------------------------------------------------------------
	assign preamp_one.gain = regs[SLOT_PRE1_GAIN][PRE_GAIN_LSB +: PRE_GAIN_W];
	assign preamp_one.source = mip_source_e'(regs[SLOT_PRE1_SRC][PRE_SRC_LSB +: PRE_SRC_W]);
	assign preamp_two.gain = regs[SLOT_PRE2_GAIN][PRE_GAIN_LSB +: PRE_GAIN_W];
	assign preamp_two.source = mip_source_e'(regs[SLOT_PRE2_SRC][PRE_SRC_LSB +: PRE_SRC_W]);
	assign preamp_two_enable = regs[SLOT_PRE2_CTRL][AMP_EN_BIT];
	assign preamp_two_mute = regs[SLOT_PRE2_CTRL][AMP_MUTE_BIT];

	// Level and mode pass straight through; software keeps the bias off while changing them
	assign bias_two.level = regs[SLOT_BIAS_SETUP][BIAS2_LEVEL_LSB +: BIAS_LEVEL_W];
	assign bias_one.level = regs[SLOT_BIAS_SETUP][BIAS1_LEVEL_LSB +: BIAS_LEVEL_W];
	assign bias_two.low_power = regs[SLOT_BIAS_SETUP][BIAS2_LP_BIT];
	assign bias_one.low_power = regs[SLOT_BIAS_SETUP][BIAS1_LP_BIT];
	assign bias_two.enable = regs[SLOT_BIAS_EN][BIAS2_EN_BIT];
	assign bias_one.enable = regs[SLOT_BIAS_EN][BIAS1_EN_BIT];

	// ----------------------------------------------------------------
	// Mixer controls
	// ----------------------------------------------------------------
	assign mixer_one.enable = regs[SLOT_MIX1_CTRL][AMP_EN_BIT];
	assign mixer_one.mute = regs[SLOT_MIX1_CTRL][AMP_MUTE_BIT];
	assign mixer_one.mix_sel = regs[SLOT_MIX1_CTRL][MIX_SEL_BIT];
	assign mixer_one.gain = applied_one;
	assign mixer_two.enable = regs[SLOT_MIX2_CTRL][AMP_EN_BIT];
	assign mixer_two.mute = regs[SLOT_MIX2_CTRL][AMP_MUTE_BIT];
	assign mixer_two.mix_sel = regs[SLOT_MIX2_CTRL][MIX_SEL_BIT];
	assign mixer_two.gain = applied_two;

	// ----------------------------------------------------------------
	// Zero-cross pins: two-flop sync, then any level change is a crossing
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			zc_meta <= 2'h0;
			zc_sync <= 2'h0;
			zc_last <= 2'h0;
		end else if (ce) begin
			zc_meta <= {zero_cross_two, zero_cross_one};
			zc_sync <= zc_meta;
			zc_last <= zc_sync;
		end
	end

	assign zc_event = zc_sync ^ zc_last;

	// ----------------------------------------------------------------
	// Ramp step timer shared by both mixers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ramp_count <= 16'h0000;
		end else if (ce) begin
			if (ramp_tick) begin
				ramp_count <= 16'h0000;
			end else begin
				ramp_count <= ramp_count + 16'h0001;
			end
		end
	end

	assign ramp_tick = (ramp_count == 16'(RAMP_STEP_CYCLES - 1));

	mip_gain_apply u_apply_one (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.target(regs[SLOT_MIX1_GAIN][MIX_GAIN_LSB +: MIX_GAIN_W]),
		.ramp_en(regs[SLOT_MIX1_CTRL][MIX_RAMP_BIT]),
		.zc_en(regs[SLOT_MIX1_CTRL][MIX_ZC_BIT]),
		.ramp_tick(ramp_tick),
		.zero_cross(zc_event[0]),
		.applied(applied_one),
		.busy(busy_one)
	);

	mip_gain_apply u_apply_two (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.target(regs[SLOT_MIX2_GAIN][MIX_GAIN_LSB +: MIX_GAIN_W]),
		.ramp_en(regs[SLOT_MIX2_CTRL][MIX_RAMP_BIT]),
		.zc_en(regs[SLOT_MIX2_CTRL][MIX_ZC_BIT]),
		.ramp_tick(ramp_tick),
		.zero_cross(zc_event[1]),
		.applied(applied_two),
		.busy(busy_two)
	);

endmodule

// ===== tb/mip_regs_properties.sv
`timescale 1ns/10ps
module mip_regs_properties
	import mip_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire mip_preamp_s preamp_one,
	input wire mip_preamp_s preamp_two,
	input wire logic preamp_two_enable,
	input wire logic preamp_two_mute,
	input wire mip_bias_s bias_one,
	input wire mip_bias_s bias_two,
	input wire mip_mixer_s mixer_one
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Write accepted, field visible next cycle
	// ----------------------------------------
	sequence wr_to(logic [7:0] idx);
		avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == idx;
	endsequence

	a_wait_answer: assert property (ce && $rose(avs_read || avs_write) |=> !avs_waitrequest)
		else $error("no answer one cycle after request");
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_ce_freeze: assert property (!ce |=> $stable(avs_waitrequest) && $stable(avs_readdata))
		else $error("bus state moved while clock enable low");
	a_read_upper: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:10] == 22'h0)
		else $error("upper read data not zero");
	a_pre1_gain: assert property (wr_to(IDX_PRE1_GAIN) |=> preamp_one.gain == $past(avs_writedata[2:0]))
		else $error("preamp one gain not applied");
	a_pre1_source: assert property (wr_to(IDX_PRE1_SRC) |=> preamp_one.source == $past(avs_writedata[1:0]))
		else $error("preamp one source not applied");
	a_pre2_gain: assert property (wr_to(IDX_PRE2_GAIN) |=> preamp_two.gain == $past(avs_writedata[2:0]))
		else $error("preamp two gain not applied");
	a_pre2_source: assert property (wr_to(IDX_PRE2_SRC) |=> preamp_two.source == $past(avs_writedata[1:0]))
		else $error("preamp two source not applied");
	a_pre2_ctrl: assert property (wr_to(IDX_PRE2_CTRL) |=>
		{preamp_two_enable, preamp_two_mute} == $past(avs_writedata[7:6]))
		else $error("preamp two enable or mute not applied");
	a_bias_setup: assert property (wr_to(IDX_BIAS_SETUP) |=>
		{bias_two.low_power, bias_two.level, bias_one.low_power, bias_one.level} == $past(avs_writedata[7:0]))
		else $error("bias setup not applied");
	a_bias_enable: assert property (wr_to(IDX_BIAS_EN) |=>
		{bias_two.enable, bias_one.enable} == {$past(avs_writedata[4]), $past(avs_writedata[0])})
		else $error("bias enables not applied");
	a_mix_ctrl: assert property (wr_to(IDX_MIX1_CTRL) |=>
		{mixer_one.enable, mixer_one.mute, mixer_one.mix_sel} == {$past(avs_writedata[7:6]), $past(avs_writedata[3])})
		else $error("mixer one control not applied");
endmodule

bind mip_regs mip_regs_properties i_props (.core_clk, .rst, .ce, .avs_address, .avs_read, .avs_write,
	.avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .preamp_one, .preamp_two,
	.preamp_two_enable, .preamp_two_mute, .bias_one, .bias_two, .mixer_one);

// ===== tb/mip_host.sv
`timescale 1ns/10ps
module mip_host (
	input wire logic core_clk,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	output logic [7:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [3:0] avs_byteenable,
	output logic [31:0] avs_writedata
);
	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_byteenable = 4'h0;
		avs_writedata = 32'h0;
	end

	task automatic access(input logic is_rd, input logic [7:0] a, input logic [7:0] d, input logic be,
		output logic [7:0] q);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= {3'h0, be};
		avs_read <= is_rd;
		avs_write <= !is_rd;
		// Only the bench watchdog ends a wait that never gets its answer
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// Stale data must not look like a held value
		avs_writedata <= ~avs_writedata;
	endtask

	// Bias is switched off around any level or mode change
	task automatic bias_cfg(input logic [7:0] setup, input logic [7:0] en);
		logic [7:0] q;
		access(1'b0, 8'hFD, 8'h00, 1'b1, q);
		access(1'b0, 8'hFC, setup, 1'b1, q);
		access(1'b0, 8'hFD, en, 1'b1, q);
	endtask
endmodule

// ===== tb/mip_regs_tb.sv
`timescale 1ns/10ps
module mip_regs_tb
	import mip_pkg::*;
;
	typedef struct {logic [7:0] a, rv, wd, ex;} mip_row_s;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic zero_cross_one = 1'b0;
	logic zero_cross_two = 1'b0;
	logic [7:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata;
	mip_preamp_s preamp_one, preamp_two;
	logic preamp_two_enable, preamp_two_mute;
	mip_bias_s bias_one, bias_two;
	mip_mixer_s mixer_one, mixer_two;
	int miscompares = 0;
	int checked = 0;
	// Address, reset value, written value, read back
	mip_row_s rows [11] = '{'{8'h2C, 8'h48, 8'hC8, 8'hC8}, '{8'h2D, 8'h03, 8'h1F, 8'h0F},
		'{8'h2E, 8'h48, 8'hDF, 8'hD8}, '{8'h2F, 8'h03, 8'h30, 8'h00}, '{8'hB5, 8'h01, 8'hFF, 8'h07},
		'{8'hB7, 8'h00, 8'hFF, 8'h03}, '{8'hB8, 8'h40, 8'hFF, 8'hC0}, '{8'hB9, 8'h01, 8'h05, 8'h05},
		'{8'hBB, 8'h00, 8'h02, 8'h02}, '{8'hFC, 8'h00, 8'hA5, 8'hA5}, '{8'hFD, 8'h00, 8'hFF, 8'h11}};

	always #4 core_clk = ~core_clk;

	mip_host i_host (.core_clk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read, .avs_write,
		.avs_byteenable, .avs_writedata);
	mip_regs #(.RAMP_STEP_CYCLES(4)) i_dut (.core_clk, .rst, .ce, .avs_address, .avs_read, .avs_write,
		.avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .zero_cross_one, .zero_cross_two,
		.preamp_one, .preamp_two, .preamp_two_enable, .preamp_two_mute, .bias_one, .bias_two, .mixer_one,
		.mixer_two);

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		i_host.access(1'b0, a, d, 1'b1, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		i_host.access(1'b1, a, 8'h00, 1'b1, q);
	endtask

	task end_of_test;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] q;
		repeat (16) @(posedge core_clk);
		cmp({preamp_two_enable, preamp_two_mute}, 2'h1);
		rst <= 1'b0;
		foreach (rows[i]) begin
			rd(rows[i].a, q);
			cmp(q, rows[i].rv);
			wr(rows[i].a, rows[i].wd);
			rd(rows[i].a, q);
			cmp(q, rows[i].ex);
		end
		cmp(preamp_one, 5'h1F);
		cmp(preamp_two, 5'h15);
		cmp({preamp_two_enable, preamp_two_mute}, 2'h3);
		cmp({bias_two, bias_one}, {5'h1A, 5'h15});
		cmp(mixer_one, 7'h7F);
		cmp(mixer_two, 7'h73);
		i_host.bias_cfg(8'h5A, 8'h11);
		@(posedge core_clk);
		cmp({bias_two, bias_one}, {5'h15, 5'h1A});
		rd(8'h10, q);
		cmp(q, 8'h00);
		i_host.access(1'b0, 8'hB9, 8'h07, 1'b0, q);
		rd(8'hB9, q);
		cmp(q, 8'h05);
		zero_cross_two <= 1'b1;
		repeat (6) @(posedge core_clk);
		cmp(mixer_two.gain, 4'h0);
		rd(8'h30, q);
		cmp(q, 8'h0F);
		wr(8'h2C, 8'hB8);
		wr(8'h2D, 8'h0B);
		repeat (2) @(posedge core_clk);
		cmp(mixer_one.gain >= 4'hE, 1'b1);
		repeat (30) @(posedge core_clk);
		cmp(mixer_one.gain, 4'hB);
		// A crossing while the clock enable is low must wait for it to rise
		wr(8'h2F, 8'h05);
		ce <= 1'b0;
		zero_cross_two <= 1'b0;
		repeat (6) @(posedge core_clk);
		cmp(mixer_two.gain, 4'h0);
		ce <= 1'b1;
		repeat (6) @(posedge core_clk);
		cmp(mixer_two.gain, 4'h5);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		cmp(mixer_one, 7'h33);
		cmp({bias_two, bias_one, preamp_one}, {10'h0, 5'h01});
		rst <= 1'b0;
		rd(8'hFC, q);
		cmp(q, 8'h00);
		end_of_test;
	end

	initial begin
		repeat (5000) @(posedge core_clk);
		miscompares++;
		end_of_test;
	end
endmodule
